// ### hdl/tpw_timer.sv
// 16-bit timer: fast and phase correct PWM with Avalon-MM registers
//
// How it works
// R1: Output action 2 gives a non-inverted, 3 an inverted fast PWM.
// R2: Compare output drives a pin only when its direction bit is set.
// R3: Fast PWM: compare match moves output one way, TOP wrap the other.
// R4: Timer tick every 1, 8, 64, 256 or 1024 clocks sets period.
// R5: Fast PWM compare of zero yields a one-tick spike each period.
// R6: Fast PWM compare equal TOP gives a constant level by polarity.
// R7: Channel A action 1 toggles on match only in selections 11 and 15.
// R8: Toggle mode keeps compare A buffered; zero toggles every tick.
// R9: Selections 1,2,3,10,11 count up to TOP then down to zero.
// R10: Phase correct TOP is 0xff, 0x1ff, 0x3ff, capture or compare A.
// R11: Count sits at TOP for one tick, then counts down.
// R12: Phase correct: up-match clears, down-match sets; inverted opposite.
// R13: Register-defined TOP from 0x0003 up to 0xffff is supported.
// R14: A channel flag sets whenever count equals its active compare.
// R15: Phase correct overflow flag sets when count reaches zero.
// R16: Phase correct loads buffered compares at TOP with A/capture flag.
// R17: Fixed TOP masks compare writes above the resolution.
// R18: Software keeps new TOP at or above every compare value.
// R19: Phase correct period runs TOP to TOP; TOP change skews slopes.
// R20: Software prefers the frequency correct mode for changing TOP.
// R21: Phase correct compare zero holds low, TOP holds high, non-inverted.
// R22: Selection 11 with channel A action 1 toggles at 50% duty.
// R23: Fast PWM counts up to 0xff/0x1ff/0x3ff, capture or A, restarts.
// R24: Fast PWM sets overflow at TOP while loading buffered compares.
// R25: Counting, matching and output change only on timer ticks.
`timescale 1ns/1ps
`default_nettype none
module tpw_timer (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output tpw_pkg::tpw_pin_t pin_drive
);
    import tpw_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tpw_ctrl_t   ctrl;
    tpw_dir_t    dir;
    tpw_dir_t    next_dir;
    logic [15:0] count_value;
    logic [15:0] next_count;
    logic [15:0] capture_top_reg;
    logic [15:0] cmp_buf [2];
    logic [15:0] cmp_act [2];
    logic [1:0]  act     [2];
    logic [3:0]  flags;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;
    logic [1:0]  pin_direction_bit;
    logic [1:0]  port_data;
    logic        compare_output [2];
    logic [1:0]  match;
    logic [1:0]  toggle_ok;
    logic        tick;
    logic        ack;
    logic        wr_go;
    logic [31:0] wval;
    logic [31:0] rdat;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic [3:0]  ws;
    logic        is_fast;
    logic        is_pc;
    logic        is_pwm;
    logic        top_by_a;
    logic        top_by_cap;
    logic        fixed_top;
    logic [15:0] top_val;
    logic [15:0] wmask;
    logic        at_top;
    logic        at_bottom;
    logic        rising;

    assign ws = ctrl.waveform_select;
    assign is_fast = ws == WS_FP8 || ws == WS_FP9 || ws == WS_FP10 ||
                     ws == WS_FP_CAP || ws == WS_FP_A;   // R23
    assign is_pc = ws == WS_PC8 || ws == WS_PC9 || ws == WS_PC10 ||
                   ws == WS_PC_CAP || ws == WS_PC_A;     // R9
    assign is_pwm = is_fast | is_pc;
    assign top_by_a = ws == WS_FP_A || ws == WS_PC_A;
    assign top_by_cap = ws == WS_FP_CAP || ws == WS_PC_CAP;
    assign fixed_top = is_pwm && !top_by_a && !top_by_cap;

    // TOP selection, register TOP may be any value 3..0xffff
    always_comb begin
        case (ws)
            WS_PC8, WS_FP8:       top_val = TOP_8;            // R10 R23
            WS_PC9, WS_FP9:       top_val = TOP_9;            // R10 R23
            WS_PC10, WS_FP10:     top_val = TOP_10;           // R10 R23
            WS_PC_CAP, WS_FP_CAP: top_val = capture_top_reg;  // R13
            WS_PC_A, WS_FP_A:     top_val = cmp_act[0];       // R13
            default:              top_val = TOP_MAX;
        endcase
    end

    assign wmask = fixed_top ? top_val : TOP_MAX;
    assign at_top = count_value == top_val;
    assign at_bottom = count_value == VAL16_RST;
    // Bottom counts as up-slope, TOP as down-slope
    assign rising = (dir == DIR_UP && !at_top) || at_bottom;

    // ------------------------------------------------------------------
    // Timer-clock enable
    // ------------------------------------------------------------------
    tpw_prescaler u_presc (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_sel (ctrl.clk_sel),
        .tick    (tick)                                   // R4
    );

    // ------------------------------------------------------------------
    // Avalon-MM slave, one wait state per access
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_go = avs_write & ack;

    // Acknowledge one cycle after the request appears
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // Byte-lane merge of write data over the current value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : merge

    // Read mux, unmapped offsets read zero
    always_comb begin
        case (avs_address)
            OFS_CTRL:   rdat = {21'h000000, ctrl};
            OFS_COUNT:  rdat = {16'h0000, count_value};
            OFS_CMPA:   rdat = {16'h0000, cmp_buf[0]};
            OFS_CMPB:   rdat = {16'h0000, cmp_buf[1]};
            OFS_CAPTOP: rdat = {16'h0000, capture_top_reg};
            OFS_FLAGS:  rdat = {28'h0000000, flags};
            OFS_PINCTL: rdat = {28'h0000000, port_data, pin_direction_bit};
            default:    rdat = 32'h00000000;
        endcase
    end

    assign wval = merge(rdat, avs_writedata, avs_byteenable);

    // Read data captured while waitrequest is still high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            avs_readdata <= rdat;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Control: waveform select, output actions, clock select
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl <= tpw_ctrl_t'(CTRL_RST);
        end else if (wr_go && avs_address == OFS_CTRL) begin
            ctrl <= tpw_ctrl_t'(wval[10:0]);
        end
    end

    // Capture register as TOP, unbuffered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            capture_top_reg <= VAL16_RST;
        end else if (wr_go && avs_address == OFS_CAPTOP) begin
            capture_top_reg <= wval[15:0];
        end
    end

    // Pin direction and plain port data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_direction_bit <= 2'h0;
            port_data         <= 2'h0;
        end else if (wr_go && avs_address == OFS_PINCTL) begin
            pin_direction_bit <= wval[1:0];
            port_data         <= wval[PIN_DATA_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Counter and slope direction
    // ------------------------------------------------------------------
    always_comb begin
        next_count = count_value + 16'h0001;
        next_dir   = DIR_UP;
        if (is_pc) begin
            case (dir)
                DIR_UP: begin
                    next_dir = DIR_UP;
                    if (at_top) begin
                        next_count = count_value - 16'h0001;  // R11
                        next_dir   = DIR_DOWN;
                    end
                end
                DIR_DOWN: begin
                    next_dir   = DIR_DOWN;
                    next_count = count_value - 16'h0001;      // R9
                    if (at_bottom) begin
                        next_count = count_value + 16'h0001;
                        next_dir   = DIR_UP;
                    end
                end
                default: begin
                    next_dir = DIR_UP;
                end
            endcase
        end else if (is_fast && at_top) begin
            next_count = VAL16_RST;                           // R23
        end
    end

    // Count steps on ticks only; a software write wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_value <= VAL16_RST;
        end else if (wr_go && avs_address == OFS_COUNT) begin
            count_value <= wval[15:0];
        end else if (tick) begin
            count_value <= next_count;                        // R25
        end
    end

    // Slope state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir <= DIR_UP;
        end else if (tick) begin
            dir <= next_dir;                                  // R9
        end
    end

    // ------------------------------------------------------------------
    // Compare channels
    // ------------------------------------------------------------------
    assign act[0] = ctrl.act_a;
    assign act[1] = ctrl.act_b;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam logic [4:0] OFS = (i == 0) ? OFS_CMPA : OFS_CMPB;

        assign match[i] = count_value == cmp_act[i];
        assign toggle_ok[i] = (i == 0) && act[i] == ACT_TOGGLE &&
                              top_by_a;                       // R7 R22

        // Buffer written by software, masked under fixed TOP
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cmp_buf[i] <= VAL16_RST;
            end else if (wr_go && avs_address == OFS) begin
                cmp_buf[i] <= wval[15:0] & wmask;             // R17
            end
        end

        // Active compare: loaded at TOP in PWM, direct otherwise
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                cmp_act[i] <= VAL16_RST;
            end else if (!is_pwm) begin
                cmp_act[i] <= cmp_buf[i];
            end else if (tick && at_top) begin
                cmp_act[i] <= cmp_buf[i];                     // R8 R16 R19 R24
            end
        end

        // Waveform register
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                compare_output[i] <= 1'b0;
            end else if (tick) begin                          // R25
                if (toggle_ok[i]) begin
                    if (match[i]) begin
                        compare_output[i] <= ~compare_output[i];  // R7 R8 R22
                    end
                end else if (is_fast && act[i][1]) begin
                    if (at_top) begin
                        compare_output[i] <= ~act[i][0];      // R1 R3 R6
                    end else if (match[i]) begin
                        compare_output[i] <= act[i][0];       // R3 R5
                    end
                end else if (is_pc && act[i][1] && match[i]) begin
                    compare_output[i] <= rising ? act[i][0]
                                                : ~act[i][0]; // R12 R21
                end
            end
        end

        // Pin mux: compare output or plain port data
        assign pin_drive.out[i] = (act[i][1] || toggle_ok[i]) ?
                                  compare_output[i] : port_data[i];
        assign pin_drive.oe[i] = pin_direction_bit[i];        // R2
    end

    // ------------------------------------------------------------------
    // Flags, write one to clear, set wins
    // ------------------------------------------------------------------
    always_comb begin
        flag_set = 4'h0;
        if (tick) begin
            flag_set[FLG_OVF] = (is_fast && at_top) ||        // R24
                                (is_pc && at_bottom &&
                                 dir == DIR_DOWN) ||          // R15
                                (!is_pwm && count_value == TOP_MAX);
            flag_set[FLG_CMPA +: 2] = match;                  // R14 R16
            flag_set[FLG_CAP] = top_by_cap && at_top;         // R16
        end
    end

    assign flag_clr = (wr_go && avs_address == OFS_FLAGS) ?
                      wval[3:0] : 4'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags <= 4'h0;
        end else begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic cnt_wr;
    assign cnt_wr = wr_go && avs_address == OFS_COUNT;

    sequence pc_top_s;
        tick && is_pc && dir == DIR_UP && at_top && !cnt_wr;
    endsequence
    sequence pc_turn_s;
        dir == DIR_DOWN && count_value == $past(count_value) - 16'h0001;
    endsequence

    fast_wrap_a: assert property (                            // R23
        tick && is_fast && at_top && !cnt_wr |=> count_value == 16'h0000)
        else $error("fast PWM did not restart from zero at TOP");
    pc_turn_a: assert property (pc_top_s |=> pc_turn_s)       // R11
        else $error("phase correct count did not turn at TOP");
    idle_hold_a: assert property (                            // R25
        !tick && !cnt_wr |=> $stable(count_value))
        else $error("count moved without a timer tick");
    fast_ovf_a: assert property (                             // R24
        tick && is_fast && at_top |=> flags[FLG_OVF])
        else $error("overflow flag missing at fast PWM TOP");
    pc_ovf_a: assert property (                               // R15
        tick && is_pc && at_bottom && dir == DIR_DOWN |=> flags[FLG_OVF])
        else $error("overflow flag missing at phase correct BOTTOM");
    match_flag_a: assert property (                           // R14
        tick && match[1] |=> flags[FLG_CMPA + 1])
        else $error("channel B match flag not set");
    fast_top_a: assert property (                             // R3
        tick && is_fast && act[0][1] && !toggle_ok[0] && at_top
        |=> compare_output[0] == !$past(act[0][0]))
        else $error("fast PWM output wrong after TOP");
    pin_dir_a: assert property (                              // R2
        pin_drive.oe == pin_direction_bit &&
        (act[1][1] || pin_drive.out[1] == port_data[1]))
        else $error("pin enable or port data wrong");
    mask_wr_a: assert property (                              // R17
        wr_go && avs_address == OFS_CMPB && fixed_top
        |=> (cmp_buf[1] & ~$past(top_val)) == 16'h0000)
        else $error("compare write not masked to resolution");

endmodule : tpw_timer
`default_nettype wire

// ### hdl/tpw_pkg.sv
// Package: register map, modes and constants of the 16-bit PWM timer
package tpw_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_COUNT  = 5'h04;
    localparam logic [4:0] OFS_CMPA   = 5'h08;
    localparam logic [4:0] OFS_CMPB   = 5'h0c;
    localparam logic [4:0] OFS_CAPTOP = 5'h10;
    localparam logic [4:0] OFS_FLAGS  = 5'h14;
    localparam logic [4:0] OFS_PINCTL = 5'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int FLG_OVF      = 0;
    localparam int FLG_CMPA     = 1;
    localparam int FLG_CAP      = 3;
    localparam int PIN_DATA_LSB = 2;
    localparam logic [10:0] CTRL_RST  = 11'h000;
    localparam logic [15:0] VAL16_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Waveform selections and fixed TOP values
    // ------------------------------------------------------------------
    localparam logic [3:0] WS_PC8    = 4'h1;
    localparam logic [3:0] WS_PC9    = 4'h2;
    localparam logic [3:0] WS_PC10   = 4'h3;
    localparam logic [3:0] WS_FP8    = 4'h5;
    localparam logic [3:0] WS_FP9    = 4'h6;
    localparam logic [3:0] WS_FP10   = 4'h7;
    localparam logic [3:0] WS_PC_CAP = 4'ha;
    localparam logic [3:0] WS_PC_A   = 4'hb;
    localparam logic [3:0] WS_FP_CAP = 4'he;
    localparam logic [3:0] WS_FP_A   = 4'hf;
    localparam logic [15:0] TOP_8    = 16'h00ff;
    localparam logic [15:0] TOP_9    = 16'h01ff;
    localparam logic [15:0] TOP_10   = 16'h03ff;
    localparam logic [15:0] TOP_MAX  = 16'hffff;

    // ------------------------------------------------------------------
    // Output actions, clock selects, prescale counts
    // ------------------------------------------------------------------
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    typedef logic [2:0] tpw_cs_t;
    localparam tpw_cs_t CS_DIV1    = 3'h1;
    localparam tpw_cs_t CS_DIV8    = 3'h2;
    localparam tpw_cs_t CS_DIV64   = 3'h3;
    localparam tpw_cs_t CS_DIV256  = 3'h4;
    localparam tpw_cs_t CS_DIV1024 = 3'h5;
    localparam logic [9:0] DIV_8    = 10'h007;
    localparam logic [9:0] DIV_64   = 10'h03f;
    localparam logic [9:0] DIV_256  = 10'h0ff;
    localparam logic [9:0] DIV_1024 = 10'h3ff;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } tpw_dir_t;

    typedef struct packed {
        tpw_cs_t    clk_sel;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [3:0] waveform_select;
    } tpw_ctrl_t;

    typedef struct packed {
        logic [1:0] oe;
        logic [1:0] out;
    } tpw_pin_t;

endpackage : tpw_pkg

// ### hdl/tpw_prescaler.sv
// Timer-clock enable divider: one-cycle tick every 1..1024 clocks
`timescale 1ns/1ps
`default_nettype none
module tpw_prescaler (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire tpw_pkg::tpw_cs_t clk_sel,
    output logic                  tick
);
    import tpw_pkg::*;

    logic [9:0] cnt;
    logic [9:0] limit;
    logic       sel_ok;

    // Terminal count for the selected divider
    always_comb begin
        case (clk_sel)
            CS_DIV8:    limit = DIV_8;
            CS_DIV64:   limit = DIV_64;
            CS_DIV256:  limit = DIV_256;
            CS_DIV1024: limit = DIV_1024;
            default:    limit = 10'h000;
        endcase
    end

    assign sel_ok = (clk_sel >= CS_DIV1) && (clk_sel <= CS_DIV1024);

    // Free divider, restarts whenever stopped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 10'h000;
        end else if (!sel_ok || cnt >= limit) begin
            cnt <= 10'h000;
        end else begin
            cnt <= cnt + 10'h001;
        end
    end

    assign tick = sel_ok && (cnt >= limit);

endmodule : tpw_prescaler
`default_nettype wire

// ### verification/tpw_load.sv
// Load model: resolves the channel A pin and counts its high cycles
`timescale 1ns/1ps
`default_nettype none
module tpw_load (
    input  wire logic              ref_clk,
    input  wire tpw_pkg::tpw_pin_t pin_drive,
    input  wire logic              start,
    input  wire logic [31:0]       window,
    output logic                   done,
    output logic [31:0]            high_cnt
);
    import tpw_pkg::*;
    logic        pin_a;
    logic [31:0] left;
    // Undriven pin floats to its pull-up
    assign pin_a = pin_drive.oe[0] ? pin_drive.out[0] : 1'b1;
    initial begin
        done = 1'b0;
        high_cnt = '0;
        left = '0;
    end
    // Count high cycles over one window after start
    always @(posedge ref_clk) begin
        done <= 1'b0;
        if (start) begin
            high_cnt <= '0;
            left <= window;
        end else if (left != 0) begin
            high_cnt <= high_cnt + {31'h0, pin_a === 1'b1};
            left <= left - 1;
            done <= (left == 1);
        end
    end
endmodule : tpw_load
`default_nettype wire

// ### verification/timer16_pwm_waveform_gen_tb_top.sv
// Testbench: register bus, PWM waveforms and load-side duty counts
`timescale 1ns/1ps
`default_nettype none
`define TPW_CHECK(got, exp) begin samples_checked++; \
    if ((got) !== (exp)) begin fails++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module timer16_pwm_waveform_gen_tb_top;
    import tpw_pkg::*;
    logic        ref_clk, rst, avs_read, avs_write, start, done;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, window, high_cnt, got, want;
    logic        avs_waitrequest;
    logic [7:0]  r;
    tpw_pin_t    pin_drive;
    logic [31:0] notes [$];
    int          fails, samples_checked, seed;

    tpw_timer u_tpw_timer (.ref_clk(ref_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_drive(pin_drive));
    tpw_load u_tpw_load (.ref_clk(ref_clk), .pin_drive(pin_drive),
        .start(start), .window(window), .done(done), .high_cnt(high_cnt));

    // Clock and hang guard
    always #4 ref_clk = ~ref_clk;
    initial begin
        #(8 * 60000);
        fails++;
        complete_run();
    end

    // Compare each result with the oldest note
    always @(negedge ref_clk) begin
        if ((avs_read && !avs_waitrequest) || done) begin
            got = done ? high_cnt : avs_readdata;
            want = notes.pop_front();
            `TPW_CHECK(got, want)
        end
    end

    // Bus cycle held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        notes.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Set mode stopped, load values, start, then measure the pin
    task automatic run(input tpw_ctrl_t c, input logic [15:0] cmp,
                       input logic [3:0] pin, input int win, input int e);
        tpw_ctrl_t s;
        s = c;
        s.clk_sel = 3'h0;
        // Stopped in normal mode, so the active compares follow the buffers
        s.waveform_select = 4'h0;
        bus(1'b1, OFS_CTRL, {21'h0, s});
        bus(1'b1, OFS_FLAGS, 32'hf);
        bus(1'b1, OFS_PINCTL, {28'h0, pin});
        bus(1'b1, OFS_CMPA, {16'h0, cmp});
        bus(1'b1, OFS_COUNT, 32'h0);
        bus(1'b1, OFS_CTRL, {21'h0, c});
        repeat (2 * win + 600) @(posedge ref_clk);
        notes.push_back(32'(e));
        window <= 32'(win);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (win + 4) @(posedge ref_clk);
    endtask : run

    task automatic complete_run();
        $display("checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        {ref_clk, avs_read, avs_write, start} = '0;
        {avs_address, avs_writedata, window} = '0;
        rst = 1'b1;
        seed = $urandom(34045);
        r = 8'($urandom());
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_FLAGS, 32'h0);
        rd(5'h1c, 32'h0);
        bus(1'b1, OFS_CTRL, {28'h0, WS_PC9});
        bus(1'b1, OFS_CMPA, 32'hffff);
        rd(OFS_CMPA, {16'h0, TOP_9});
        bus(1'b1, OFS_CMPB, 32'hfe00);
        rd(OFS_CMPB, {16'h0, 16'hfe00 & TOP_9});
        run('{CS_DIV1, 2'h0, 2'h2, WS_FP8}, 16'h0, 4'h1, 256, 1);
        rd(OFS_FLAGS, 32'h7);
        run('{CS_DIV1, 2'h0, 2'h2, WS_FP8}, TOP_8, 4'h1, 256, 256);
        run('{CS_DIV1, 2'h0, 2'h3, WS_FP8}, TOP_8, 4'h1, 256, 0);
        run('{CS_DIV1, 2'h0, 2'h2, WS_FP8}, {8'h0, r}, 4'h1, 256,
            int'(r) + 1);
        run('{CS_DIV1, 2'h0, 2'h3, WS_FP8}, {8'h0, r}, 4'h1, 256,
            255 - int'(r));
        run('{CS_DIV1, 2'h0, 2'h2, WS_FP8}, 16'h0, 4'h0, 256, 256);
        run('{CS_DIV1, 2'h0, 2'h1, WS_FP8}, 16'h0, 4'h5, 256, 256);
        run('{CS_DIV8, 2'h0, 2'h2, WS_FP8}, 16'h0, 4'h1, 2048, 8);
        run('{CS_DIV1, 2'h0, 2'h1, WS_FP_A}, 16'h0, 4'h1, 256, 128);
        run('{CS_DIV1, 2'h0, 2'h1, WS_PC_A}, 16'h3, 4'h1, 12, 6);
        rd(OFS_FLAGS, 32'h7);
        run('{CS_DIV1, 2'h0, 2'h2, WS_PC8}, 16'h0, 4'h1, 510, 0);
        run('{CS_DIV1, 2'h0, 2'h2, WS_PC8}, TOP_8, 4'h1, 510, 510);
        run('{CS_DIV1, 2'h0, 2'h3, WS_PC8}, 16'h0, 4'h1, 510, 510);
        complete_run();
    end
endmodule : timer16_pwm_waveform_gen_tb_top
`default_nettype wire
